// >>> hw/sdi_pkg.sv
// constants and carrier types of the strobe parallel display input
package sdi_pkg;

  // documented register of the displayed value
  localparam logic [7:0] REG_DISPLAYED_VALUE_OFFSET = 8'h01;

  // coding modes
  localparam logic [1:0] CODE_BCD = 2'h0;
  localparam logic [1:0] CODE_HEX = 2'h1;
  localparam logic [1:0] CODE_RAW = 2'h2;
  localparam logic [1:0] CODE_CHAR = 2'h3;

  // entry modes
  localparam logic [1:0] ENTRY_COMMON = 2'h0;
  localparam logic [1:0] ENTRY_PER_DECADE = 2'h1;
  localparam logic [1:0] ENTRY_ADDRESSED = 2'h2;

  // strobe activity
  localparam logic [1:0] STROBE_HIGH = 2'h0;
  localparam logic [1:0] STROBE_LOW = 2'h1;
  localparam logic [1:0] STROBE_FALL = 2'h2;
  localparam logic [1:0] STROBE_RISE = 2'h3;

  // point settings: 0..3 blank leading zeros, 4..7 show all positions
  localparam logic [2:0] POINT_LAST_BLANKING = 3'h3;
  localparam logic [2:0] POINT_FIRST_FULL = 3'h4;

  // data source
  localparam logic SOURCE_PARALLEL = 1'b0;
  localparam logic SOURCE_SERIAL = 1'b1;

  // brightness range
  localparam logic [3:0] BRIGHT_MIN = 4'h1;
  localparam logic [3:0] BRIGHT_MAX = 4'h8;

  // refresh timeout range in seconds, zero disables
  localparam logic [6:0] TIMEOUT_OFF_S = 7'h00;
  localparam logic [6:0] TIMEOUT_MAX_S = 7'h63;

  // segment patterns, bit 0 = segment A .. bit 6 = segment G, bit 7 = point
  localparam logic [7:0] SEG_DASH = 8'h40;
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [3:0] MINUS_NIBBLE = 4'hF;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // reset values
  localparam logic [7:0] DECADE_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_PERIOD_US = 800;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int FLASH_HALF_PERIOD_MS = 500;
  localparam int FLASH_HALF_CYCLES = (FLASH_HALF_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  typedef struct packed {
    logic source;
    logic [1:0] coding;
    logic [1:0] entry;
    logic [1:0] strobe_mode;
    logic [2:0] point;
    logic [3:0] brightness;
    logic [6:0] timeout_s;
  } sdi_cfg_type;

  typedef struct packed {
    logic [15:0] data;
    logic [3:0] strobe;
    logic decade_addr_high;
    logic decade_addr_low;
    logic enable_n;
  } sdi_pins_type;

endpackage

// >>> hw/sdi_glyph_decode.sv
// one decade: coding of a stored byte into a seven-segment pattern
module sdi_glyph_decode
  import sdi_pkg::*;
(
  input wire logic [1:0] coding,
  input wire logic [7:0] byte_in,
  input wire logic point_on,
  input wire logic blank,
  output logic [7:0] seg
);

  function automatic logic [6:0] hex_glyph(input logic [3:0] n);
    logic [6:0] g;
    g = 7'h00;
    unique case (n)
      4'h0: g = 7'h3F;
      4'h1: g = 7'h06;
      4'h2: g = 7'h5B;
      4'h3: g = 7'h4F;
      4'h4: g = 7'h66;
      4'h5: g = 7'h6D;
      4'h6: g = 7'h7D;
      4'h7: g = 7'h07;
      4'h8: g = 7'h7F;
      4'h9: g = 7'h6F;
      4'hA: g = 7'h77;
      4'hB: g = 7'h7C;
      4'hC: g = 7'h39;
      4'hD: g = 7'h5E;
      4'hE: g = 7'h79;
      4'hF: g = 7'h71;
    endcase
    return g;
  endfunction

  // fixed table, codes without a glyph show blank
  function automatic logic [6:0] char_glyph(input logic [6:0] c);
    logic [6:0] g;
    g = 7'h00;
    if (c >= 7'h30 && c <= 7'h39) begin
      g = hex_glyph(c[3:0]);
    end else begin
      case (c)
        7'h2D: g = 7'h40;
        7'h5F: g = 7'h08;
        7'h3D: g = 7'h48;
        7'h41, 7'h61: g = 7'h77;
        7'h42, 7'h62: g = 7'h7C;
        7'h43: g = 7'h39;
        7'h63: g = 7'h58;
        7'h44, 7'h64: g = 7'h5E;
        7'h45, 7'h65: g = 7'h79;
        7'h46, 7'h66: g = 7'h71;
        7'h47, 7'h67: g = 7'h3D;
        7'h48: g = 7'h76;
        7'h68: g = 7'h74;
        7'h49, 7'h69: g = 7'h06;
        7'h4A, 7'h6A: g = 7'h1E;
        7'h4C, 7'h6C: g = 7'h38;
        7'h4E, 7'h6E: g = 7'h54;
        7'h4F: g = 7'h3F;
        7'h6F: g = 7'h5C;
        7'h50, 7'h70: g = 7'h73;
        7'h52, 7'h72: g = 7'h50;
        7'h53, 7'h73: g = 7'h6D;
        7'h54, 7'h74: g = 7'h78;
        7'h55: g = 7'h3E;
        7'h75: g = 7'h1C;
        7'h59, 7'h79: g = 7'h6E;
        default: g = 7'h00;
      endcase
    end
    return g;
  endfunction

  always_comb begin
    seg = SEG_BLANK;
    unique case (coding)
      CODE_BCD: begin
        if (blank) begin
          seg = SEG_BLANK;
        end else if (byte_in[3:0] <= DIGIT_MAX) begin
          seg = {1'b0, hex_glyph(byte_in[3:0])};
        end else if (byte_in[3:0] == MINUS_NIBBLE) begin
          seg = SEG_DASH;
        end
        seg[7] = point_on;
      end
      CODE_HEX: begin
        seg = blank ? SEG_BLANK : {1'b0, hex_glyph(byte_in[3:0])};
        seg[7] = point_on;
      end
      CODE_RAW: seg = byte_in;
      CODE_CHAR: seg = {point_on, char_glyph(byte_in[6:0])};
    endcase
  end

endmodule

// >>> hw/sdi_display_input.sv
// parallel strobe input, decade storage and display decoding
// Behaviour
// - brightness levels one to eight set the display drive duty
// - data comes from parallel or serial source; coding and point settings held
// - decimal coding: nibbles 0..9 show digits, 0xF shows minus
// - hexadecimal coding shows characters 0 to F
// - lines one to four weigh 1, 2, 4, 8
// - decimal coding yields a signed 16-bit displayed value
// - other codings read zero as displayed value
// - raw coding: decade one lines drive A-D, decade two E, F, G, point
// - character coding: decade one bits 0-3, decade two 4-7, bit 7 ignored
// - point setting applies in decimal, hexadecimal and character coding
// - common strobe latches all decades from their own lines
// - raw and character coding turn common strobe into per-decade strobe
// - per-decade strobe: own strobe each, shared data lines
// - addressed entry stores only with strobe active and enable low
// - address 00..11 selects decade one..four, high line is msb
// - high level strobe follows data while high, keeps last
// - low level strobe follows data while low, keeps last
// - falling edge latches data present before the edge
// - rising edge latches data present before the edge
// - strobes sampled every 0.8 ms period
// - refresh timeout 0..99 s flashes display, zero disables
// - dashes shown until first store
// - on timeout alternate stored data and dashes until new store
module sdi_display_input
  import sdi_pkg::*;
#(
  parameter int SAMPLE_TICK_CYCLES = SAMPLE_CYCLES,
  parameter int FLASH_TICK_CYCLES = FLASH_HALF_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire sdi_cfg_type cfg,
  input wire sdi_pins_type pins,
  input wire logic [31:0] serial_data,
  input wire logic serial_store,
  output logic [31:0] segments,
  output logic led_enable,
  output logic [15:0] displayed_value_signed,
  output logic refresh_timeout,
  output logic data_valid,
  output logic [3:0] strobe_state,
  output logic [15:0] data_state
);

  typedef struct packed {
    sdi_pins_type pins_s1;
    sdi_pins_type pins_s2;
    logic [23:0] tick_cnt;
    logic [3:0] prev_active;
    logic [15:0] prev_data;
    logic primed;
    logic [1:0] mode_seen;
    logic [1:0] entry_seen;
    logic [3:0][7:0] dec_data;
    logic have_data;
    logic [23:0] flash_cnt;
    logic blink;
    logic [7:0] tout_cnt;
    logic timed_out;
    logic [2:0] pwm_cnt;
    logic [31:0] seg_out;
    logic led_on;
    logic [15:0] value;
    logic [3:0] strobe_seen;
    logic [15:0] data_seen;
  } sdi_state_type;

  localparam sdi_state_type STATE_RESET = '{
    pins_s1: '0,
    pins_s2: '0,
    tick_cnt: 24'h000000,
    prev_active: 4'h0,
    prev_data: 16'h0000,
    primed: 1'b0,
    mode_seen: STROBE_HIGH,
    entry_seen: ENTRY_COMMON,
    dec_data: {4{DECADE_RESET}},
    have_data: 1'b0,
    flash_cnt: 24'h000000,
    blink: 1'b0,
    tout_cnt: 8'h00,
    timed_out: 1'b0,
    pwm_cnt: 3'h0,
    seg_out: {4{SEG_DASH}},
    led_on: 1'b0,
    value: VALUE_RESET,
    strobe_seen: 4'h0,
    data_seen: 16'h0000
  };

  sdi_state_type st_ff;
  sdi_state_type nxt_st;

  logic [3:0][7:0] glyph;
  logic [3:0] blank_mask;
  logic [3:0] point_mask;

  // signed value of the shown decimal digits
  function automatic logic [15:0] decimal_value(input logic [3:0][7:0] dec,
                                                input logic [3:0] blank);
    logic [15:0] acc;
    logic found;
    logic neg;
    logic [3:0] n;
    acc = 16'h0000;
    found = 1'b0;
    neg = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      n = dec[i][3:0];
      if (!found && !blank[i] && (n <= DIGIT_MAX || n == MINUS_NIBBLE)) begin
        found = 1'b1;
        neg = (n == MINUS_NIBBLE);
      end
      // blanks and minus signs below the top count as zero
      acc = 16'(acc * 16'h000A);
      if (found && n <= DIGIT_MAX && !blank[i]) begin
        acc = 16'(acc + {12'h000, n});
      end
    end
    return neg ? 16'(16'h0000 - acc) : acc;
  endfunction

  function automatic logic [3:0] clamp_level(input logic [3:0] b);
    logic [3:0] l;
    l = b;
    if (b < BRIGHT_MIN) begin
      l = BRIGHT_MIN;
    end else if (b > BRIGHT_MAX) begin
      l = BRIGHT_MAX;
    end
    return l;
  endfunction

  // point position and leading-zero blanking
  always_comb begin
    logic [1:0] pidx;
    logic blanking;
    logic numeric;
    logic above_blank;
    pidx = (cfg.point >= POINT_FIRST_FULL) ? 2'(cfg.point - POINT_FIRST_FULL) : cfg.point[1:0];
    blanking = (cfg.point <= POINT_LAST_BLANKING);
    numeric = (cfg.coding == CODE_BCD) || (cfg.coding == CODE_HEX);
    above_blank = 1'b1;
    point_mask = 4'h0;
    blank_mask = 4'h0;
    if (cfg.coding != CODE_RAW && pidx != 2'h0) begin
      point_mask[pidx] = 1'b1;
    end
    for (int i = 3; i >= 1; i--) begin
      if (numeric && blanking && above_blank && i > int'(pidx)
          && st_ff.dec_data[i][3:0] == 4'h0) begin
        blank_mask[i] = 1'b1;
      end else begin
        above_blank = 1'b0;
      end
    end
  end

  for (genvar d = 0; d < 4; d++) begin : g_decade
    sdi_glyph_decode u_glyph (
      .coding(cfg.coding),
      .byte_in(st_ff.dec_data[d]),
      .point_on(point_mask[d]),
      .blank(blank_mask[d]),
      .seg(glyph[d])
    );
  end

  always_comb begin
    logic tick;
    logic flash_tick;
    logic [3:0] active;
    logic [3:0] ev;
    logic [15:0] src;
    logic [1:0] entry;
    logic [1:0] addr;
    logic [3:0] load;
    logic stored;
    logic show_dash;
    logic rearm;
    sdi_pins_type p;
    tick = 1'b0;
    flash_tick = 1'b0;
    active = 4'h0;
    ev = 4'h0;
    src = 16'h0000;
    entry = cfg.entry;
    addr = 2'h0;
    load = 4'h0;
    stored = 1'b0;
    show_dash = 1'b0;
    rearm = 1'b0;
    p = st_ff.pins_s2;
    nxt_st = st_ff;

    // two-stage pin synchroniser
    nxt_st.pins_s1 = pins;
    nxt_st.pins_s2 = st_ff.pins_s1;

    // strobe sampling period
    if (st_ff.tick_cnt >= 24'(SAMPLE_TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = 24'h000000;
      tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = 24'(st_ff.tick_cnt + 24'h000001);
    end

    active = (cfg.strobe_mode == STROBE_LOW) ? ~p.strobe : p.strobe;
    unique case (cfg.strobe_mode)
      STROBE_HIGH: begin
        ev = active;
        src = p.data;
      end
      STROBE_LOW: begin
        ev = active;
        src = p.data;
      end
      STROBE_FALL: begin
        ev = st_ff.prev_active & ~active;
        src = st_ff.prev_data;
      end
      STROBE_RISE: begin
        ev = ~st_ff.prev_active & active;
        src = st_ff.prev_data;
      end
    endcase

    if ((cfg.coding == CODE_RAW || cfg.coding == CODE_CHAR) && entry == ENTRY_COMMON) begin
      entry = ENTRY_PER_DECADE;
    end
    addr = {p.decade_addr_high, p.decade_addr_low};

    // a mode change re-arms the edge history for one tick, so an idle
    // strobe level cannot pose as a fresh edge after reset or a switch
    rearm = (cfg.strobe_mode != st_ff.mode_seen) || (entry != st_ff.entry_seen);
    nxt_st.mode_seen = cfg.strobe_mode;
    nxt_st.entry_seen = entry;
    if (rearm) begin
      nxt_st.primed = 1'b0;
    end else if (tick) begin
      nxt_st.primed = 1'b1;
    end

    if (tick && st_ff.primed && !rearm && cfg.source == SOURCE_PARALLEL) begin
      nxt_st.prev_active = active;
      nxt_st.prev_data = p.data;
      for (int d = 0; d < 4; d++) begin
        unique case (entry)
          ENTRY_COMMON: begin
            if (ev[0]) begin
              load[d] = 1'b1;
              nxt_st.dec_data[d] = {4'h0, src[4*d +: 4]};
            end
          end
          ENTRY_PER_DECADE: begin
            if (ev[d]) begin
              load[d] = 1'b1;
              nxt_st.dec_data[d] = src[7:0];
            end
          end
          default: begin
            if (ev[0] && !p.enable_n && addr == 2'(d)) begin
              load[d] = 1'b1;
              nxt_st.dec_data[d] = src[7:0];
            end
          end
        endcase
      end
    end else if (tick) begin
      // priming tick or serial source: history only
      nxt_st.prev_active = active;
      nxt_st.prev_data = p.data;
    end

    if (cfg.source == SOURCE_SERIAL && serial_store) begin
      nxt_st.dec_data = serial_data;
      stored = 1'b1;
    end
    stored = stored | (|load);

    // half-second flash base, also the timeout unit
    if (st_ff.flash_cnt >= 24'(FLASH_TICK_CYCLES - 1)) begin
      nxt_st.flash_cnt = 24'h000000;
      flash_tick = 1'b1;
      nxt_st.blink = ~st_ff.blink;
    end else begin
      nxt_st.flash_cnt = 24'(st_ff.flash_cnt + 24'h000001);
    end

    if (stored) begin
      nxt_st.have_data = 1'b1;
      nxt_st.tout_cnt = 8'h00;
      nxt_st.timed_out = 1'b0;
    end else if (cfg.timeout_s == TIMEOUT_OFF_S || cfg.timeout_s > TIMEOUT_MAX_S) begin
      nxt_st.tout_cnt = 8'h00;
      nxt_st.timed_out = 1'b0;
    end else if (flash_tick) begin
      if (st_ff.tout_cnt != 8'hFF) begin
        nxt_st.tout_cnt = 8'(st_ff.tout_cnt + 8'h01);
      end
      if (8'(st_ff.tout_cnt + 8'h01) >= {cfg.timeout_s, 1'b0}) begin
        nxt_st.timed_out = 1'b1;
      end
    end

    show_dash = !st_ff.have_data || (st_ff.timed_out && st_ff.blink);
    nxt_st.seg_out = show_dash ? {4{SEG_DASH}} : glyph;

    if (cfg.coding == CODE_BCD && st_ff.have_data) begin
      nxt_st.value = decimal_value(st_ff.dec_data, blank_mask);
    end else begin
      nxt_st.value = VALUE_RESET;
    end

    nxt_st.pwm_cnt = 3'(st_ff.pwm_cnt + 3'h1);
    nxt_st.led_on = ({1'b0, st_ff.pwm_cnt} < clamp_level(cfg.brightness));

    nxt_st.strobe_seen = p.strobe;
    nxt_st.data_seen = p.data;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign segments = st_ff.seg_out;
  assign led_enable = st_ff.led_on;
  assign displayed_value_signed = st_ff.value;
  assign refresh_timeout = st_ff.timed_out;
  assign data_valid = st_ff.have_data;
  assign strobe_state = st_ff.strobe_seen;
  assign data_state = st_ff.data_seen;

endmodule

// >>> verification/sdi_display_input_chk.sv
// assertion checker of the strobe parallel display input
module sdi_display_input_chk
  import sdi_pkg::*;
#(
  parameter int SAMPLE_TICK_CYCLES = 8,
  parameter int FLASH_TICK_CYCLES = 20
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire sdi_cfg_type cfg,
  input wire sdi_pins_type pins,
  input wire logic [31:0] serial_data,
  input wire logic serial_store,
  input wire logic [31:0] segments,
  input wire logic led_enable,
  input wire logic [15:0] displayed_value_signed,
  input wire logic refresh_timeout,
  input wire logic data_valid,
  input wire logic [3:0] strobe_state,
  input wire logic [15:0] data_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] since_ff;
  logic ser_raw;
  assign ser_raw = serial_store && cfg.source == SOURCE_SERIAL && cfg.coding == CODE_RAW;
  // cycles since reset release, saturating
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      since_ff <= 2'h0;
    end else if (since_ff != 2'h3) begin
      since_ff <= since_ff + 2'h1;
    end
  end
  a_reset_clear: assert property ($fell(rst) |-> segments == 32'h40404040
    && !data_valid && !refresh_timeout) else $error("state not cleared by reset");
  a_nodata_dash: assert property (!data_valid |-> segments == 32'h40404040)
    else $error("no dashes before first store");
  a_valid_holds: assert property (data_valid |=> data_valid)
    else $error("data valid dropped");
  a_value_zero: assert property ((cfg.coding != CODE_BCD)[*3]
    |-> displayed_value_signed == 16'h0000) else $error("value not zero");
  a_serial_raw: assert property (ser_raw && cfg.timeout_s == TIMEOUT_OFF_S
    |=> ##1 segments == $past(serial_data, 2) && data_valid)
    else $error("raw serial byte not shown");
  a_store_clears: assert property (serial_store && cfg.source == SOURCE_SERIAL
    |=> !refresh_timeout) else $error("store left timeout set");
  a_timeout_cfg: assert property ($rose(refresh_timeout)
    |-> $past(cfg.timeout_s) != TIMEOUT_OFF_S) else $error("timeout while disabled");
  a_full_bright: assert property ((cfg.brightness == BRIGHT_MAX)[*8] |-> led_enable)
    else $error("full brightness not steady");
  a_min_bright: assert property ((cfg.brightness == BRIGHT_MIN)[*3]
    |-> !(led_enable && $past(led_enable))) else $error("minimum brightness too long");
  a_sync_levels: assert property (since_ff == 2'h3
    |-> strobe_state == $past(pins.strobe, 3) && data_state == $past(pins.data, 3))
    else $error("pin state not tracking");
  c_stored: cover property ($rose(data_valid));
  c_timed_out: cover property (data_valid && refresh_timeout);
  c_addressed: cover property (cfg.entry == ENTRY_ADDRESSED && !pins.enable_n);
endmodule

bind sdi_display_input sdi_display_input_chk #(
  .SAMPLE_TICK_CYCLES(SAMPLE_TICK_CYCLES),
  .FLASH_TICK_CYCLES(FLASH_TICK_CYCLES)
) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .cfg(cfg),
  .pins(pins),
  .serial_data(serial_data),
  .serial_store(serial_store),
  .segments(segments),
  .led_enable(led_enable),
  .displayed_value_signed(displayed_value_signed),
  .refresh_timeout(refresh_timeout),
  .data_valid(data_valid),
  .strobe_state(strobe_state),
  .data_state(data_state)
);

// >>> verification/sdi_ctrl_model.sv
// model of the controller driving the parallel data and strobe lines
module sdi_ctrl_model
  import sdi_pkg::*;
#(
  parameter int HOLD_CYCLES = 24
)
(
  input wire logic clk_sys,
  output sdi_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = '0;
  // every change is held three sample periods before the next one
  task automatic put(input logic [15:0] d, input logic [1:0] a, input logic en_n);
    @(posedge clk_sys);
    pins.data <= d;
    pins.decade_addr_high <= a[1];
    pins.decade_addr_low <= a[0];
    pins.enable_n <= en_n;
    repeat (HOLD_CYCLES) @(posedge clk_sys);
  endtask
  task automatic strobe(input logic [3:0] s);
    @(posedge clk_sys);
    pins.strobe <= s;
    repeat (HOLD_CYCLES) @(posedge clk_sys);
  endtask
endmodule

// >>> verification/test_strobe_parallel_display_input.sv
// self-checking bench of the strobe parallel display input
module test_strobe_parallel_display_input
  import sdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sdi_cfg_type cfg;
  sdi_pins_type pins;
  logic [31:0] serial_data = 32'h0;
  logic serial_store = 1'b0;
  logic [31:0] segments;
  logic led_enable;
  logic [15:0] displayed_value_signed;
  logic refresh_timeout;
  logic data_valid;
  logic [3:0] strobe_state;
  logic [15:0] data_state;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  sdi_display_input #(.SAMPLE_TICK_CYCLES(8), .FLASH_TICK_CYCLES(20)) DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .cfg(cfg),
    .pins(pins),
    .serial_data(serial_data),
    .serial_store(serial_store),
    .segments(segments),
    .led_enable(led_enable),
    .displayed_value_signed(displayed_value_signed),
    .refresh_timeout(refresh_timeout),
    .data_valid(data_valid),
    .strobe_state(strobe_state),
    .data_state(data_state)
  );
  sdi_ctrl_model #(.HOLD_CYCLES(24)) u_ctrl (.clk_sys(clk_sys), .pins(pins));

  initial forever #25 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] hex7(input logic [3:0] n);
    logic [127:0] t;
    t = 128'h71795E397C776F7F077D6D664F5B063F;
    return t[n * 8 +: 8];
  endfunction

  task automatic setup(input logic [1:0] code, input logic [1:0] ent, input logic [1:0] md,
                       input logic [3:0] idle);
    @(posedge clk_sys);
    cfg.coding <= code;
    cfg.entry <= ent;
    cfg.strobe_mode <= md;
    u_ctrl.strobe(idle);
  endtask

  task automatic t_bcd_common();
    setup(CODE_BCD, ENTRY_COMMON, STROBE_RISE, 4'h0);
    u_ctrl.put(16'hF201, 2'h0, 1'b0);
    check(32'(data_state), 32'h0000F201);
    u_ctrl.strobe(4'h1);
    check(32'(strobe_state), 32'h00000001);
    check(segments, 32'h405B3F06);
    check(32'(displayed_value_signed), 32'h0000FF37);
    cfg.point <= 3'h1;
    u_ctrl.put(16'h0D12, 2'h0, 1'b0);
    u_ctrl.strobe(4'h0);
    u_ctrl.strobe(4'h1);
    check(segments, 32'h0000865B);
    check(32'(displayed_value_signed), 32'h0000000C);
    cfg.point <= POINT_FIRST_FULL;
  endtask

  task automatic t_hex_fall();
    setup(CODE_HEX, ENTRY_PER_DECADE, STROBE_FALL, 4'hF);
    for (int i = 0; i < 4; i++) begin
      u_ctrl.put({12'h000, 4'hA + 4'(i)}, 2'h0, 1'b0);
      u_ctrl.strobe(4'hF ^ (4'h1 << i));
      check(32'(segments[i * 8 +: 8]), 32'(hex7(4'hA + 4'(i))));
      u_ctrl.strobe(4'hF);
    end
    u_ctrl.put(16'h0003, 2'h0, 1'b0);
    check(segments, 32'h5E397C77);
    check(32'(displayed_value_signed), 32'h0);
  endtask

  task automatic t_raw_levels();
    setup(CODE_RAW, ENTRY_COMMON, STROBE_HIGH, 4'h0);
    u_ctrl.put(16'h00A5, 2'h0, 1'b0);
    u_ctrl.strobe(4'h2);
    check(32'(segments[15:8]), 32'hA5);
    u_ctrl.put(16'h005A, 2'h0, 1'b0);
    check(32'(segments[15:8]), 32'h5A);
    u_ctrl.strobe(4'h0);
    u_ctrl.put(16'h0011, 2'h0, 1'b0);
    check(32'(segments[15:8]), 32'h5A);
    setup(CODE_RAW, ENTRY_PER_DECADE, STROBE_LOW, 4'hF);
    u_ctrl.put(16'h0081, 2'h0, 1'b0);
    u_ctrl.strobe(4'hB);
    check(32'(segments[23:16]), 32'h81);
    u_ctrl.strobe(4'hF);
    u_ctrl.put(16'h0018, 2'h0, 1'b0);
    check(32'(segments[23:16]), 32'h81);
  endtask

  task automatic t_addressed();
    setup(CODE_RAW, ENTRY_ADDRESSED, STROBE_RISE, 4'h0);
    check(segments, 32'h0D815A0A);
    u_ctrl.put(16'h00EE, 2'h3, 1'b1);
    u_ctrl.strobe(4'h1);
    u_ctrl.strobe(4'h0);
    check(segments, 32'h0D815A0A);
    for (int a = 0; a < 4; a++) begin
      u_ctrl.put({8'h00, 8'h30 + 8'(a)}, 2'(a), 1'b0);
      u_ctrl.strobe(4'h1);
      check(32'(segments[a * 8 +: 8]), 32'h30 + 32'(a));
      u_ctrl.strobe(4'h0);
    end
  endtask

  task automatic t_char_bright();
    int highs;
    setup(CODE_CHAR, ENTRY_PER_DECADE, STROBE_RISE, 4'h0);
    u_ctrl.put(16'h00B1, 2'h0, 1'b0);
    u_ctrl.strobe(4'h1);
    check(32'(segments[7:0]), 32'h06);
    highs = 0;
    cfg.brightness <= 4'h6;
    repeat (16) @(posedge clk_sys);
    repeat (8) begin
      @(posedge clk_sys);
      highs += int'(led_enable === 1'b1);
    end
    check(32'(highs), 32'h6);
    cfg.brightness <= BRIGHT_MIN;
    repeat (16) @(posedge clk_sys);
    cfg.brightness <= BRIGHT_MAX;
  endtask

  task automatic send(input logic [31:0] d);
    @(posedge clk_sys);
    serial_data <= d;
    serial_store <= 1'b1;
    @(posedge clk_sys);
    serial_store <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_serial_timeout();
    int dash;
    int shown;
    setup(CODE_RAW, ENTRY_PER_DECADE, STROBE_RISE, 4'h0);
    cfg.source <= SOURCE_SERIAL;
    send(32'h12345678);
    check(segments, 32'h12345678);
    cfg.timeout_s <= 7'h01;
    repeat (60) @(posedge clk_sys);
    check(32'(refresh_timeout), 32'h1);
    dash = 0;
    shown = 0;
    repeat (40) begin
      @(posedge clk_sys);
      dash += int'(segments === 32'h40404040);
      shown += int'(segments === 32'h12345678);
    end
    check(32'(dash > 0 && shown > 0), 32'h1);
    send(32'h0F0F0F0F);
    check(32'(refresh_timeout), 32'h0);
    cfg.timeout_s <= TIMEOUT_OFF_S;
    cfg.source <= SOURCE_PARALLEL;
  endtask

  task automatic t_reset_again();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(segments, 32'h40404040);
    check(32'(data_valid), 32'h0);
    check(32'(refresh_timeout), 32'h0);
  endtask

  initial begin
    cfg = '{SOURCE_PARALLEL, CODE_BCD, ENTRY_COMMON, STROBE_RISE, POINT_FIRST_FULL,
            BRIGHT_MAX, TIMEOUT_OFF_S};
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(segments, 32'h40404040);
    check(32'(data_valid), 32'h0);
    t_bcd_common();
    t_hex_fall();
    t_raw_levels();
    t_addressed();
    t_char_bright();
    t_serial_timeout();
    t_reset_again();
    conclude();
  end
endmodule
